// [core/cbbx_pkg.sv]
// Constants, instruction encoding, state codes and carrier types for the bit, branch,
// system-control and block-copy execute core.
// Assumes one 125 MHz clock and a word-wide memory that answers a read one cycle later.
package cbbx_pkg;

  localparam int unsigned CBBX_ADDR_W = 24;

  // Leading four bits of every instruction word select the operation class.
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_BIT = 4'h1;
  localparam logic [3:0] OP_BCC = 4'h2;
  localparam logic [3:0] OP_JMP = 4'h3;
  localparam logic [3:0] OP_BSR = 4'h4;
  localparam logic [3:0] OP_RTS = 4'h5;
  localparam logic [3:0] OP_SLP = 4'h6;
  localparam logic [3:0] OP_LDC = 4'h7;
  localparam logic [3:0] OP_STC = 4'h8;
  localparam logic [3:0] OP_LOGC = 4'h9;
  localparam logic [3:0] OP_COPY = 4'hA;
  localparam logic [3:0] OP_RTE = 4'hB;

  // Bit functions in the carry group.
  localparam logic [2:0] BF_XOR = 3'h0;
  localparam logic [2:0] BF_IXOR = 3'h1;
  localparam logic [2:0] BF_LD = 3'h2;
  localparam logic [2:0] BF_ILD = 3'h3;
  localparam logic [2:0] BF_ST = 3'h4;
  localparam logic [2:0] BF_IST = 3'h5;

  // Immediate logic functions on a control register.
  localparam logic [1:0] LF_AND = 2'h0;
  localparam logic [1:0] LF_OR = 2'h1;
  localparam logic [1:0] LF_XOR = 2'h2;

  // Control-register load sources.
  localparam logic [1:0] LS_REG = 2'h0;
  localparam logic [1:0] LS_MEM = 2'h1;
  localparam logic [1:0] LS_IMM = 2'h2;

  // Condition-code bit positions.
  localparam int unsigned CC_C = 0;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_N = 3;

  // Fixed general registers.
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_SRC = 3'h5;
  localparam logic [2:0] REG_DST = 3'h6;
  localparam logic [2:0] REG_SP = 3'h7;

  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [31:0] SP_WORD = 32'h00000002;
  localparam logic [31:0] SP_FRAME = 32'h00000004;
  localparam logic [31:0] PTR_STEP = 32'h00000001;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [23:0] RESET_PC = 24'h000000;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [7:0] EXR_RESET = 8'h00;

  // Register port offsets.
  localparam logic [7:0] RA_CTRL = 8'h00;
  localparam logic [7:0] RA_STATUS = 8'h04;
  localparam logic [7:0] RA_PC = 8'h08;
  localparam logic [7:0] RA_FLAGS = 8'h0C;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned STAT_SLEEP = 0;
  localparam int unsigned STAT_ILLEGAL = 1;

  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_DECODE = 4'h1,
    ST_EXT_HI = 4'h2,
    ST_EXT_LO = 4'h3,
    ST_BIT_RD = 4'h4,
    ST_LDC_RD = 4'h5,
    ST_POP_CCR = 4'h6,
    ST_POP_HI = 4'h7,
    ST_POP_LO = 4'h8,
    ST_PUSH_HI = 4'h9,
    ST_PUSH_LO = 4'hA,
    ST_CPY = 4'hB,
    ST_SLEEP = 4'hC
  } cbbx_state_t;

  // One memory request; byte accesses carry data in the low eight bits.
  typedef struct packed {
    logic rd;
    logic wr;
    logic byte_acc;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cbbx_mem_t;

  // Software register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cbbx_reg_req_t;

  typedef struct packed {
    cbbx_state_t st;
    logic [23:0] pc;
    logic [7:0] condition_code_reg;
    logic [7:0] extended_ctrl_reg;
    logic [7:0][31:0] gpr;
    logic [15:0] ir;
    logic [23:0] tgt;
    logic pend;
    logic rvalid;
    cbbx_mem_t mem;
    logic run;
    logic illegal;
    logic sleeping;
    logic [31:0] reg_rdata;
  } cbbx_core_t;

endpackage

// [core/cbbx_core.sv]
// Execute core for the carry bit group, conditional branches, jumps and calls,
// control-register instructions and the block copy.
// Assumes memory on the same clock that returns read data in the cycle after mem.rd
// and accepts a write in the single cycle mem.wr is high.
//
// Contract
// - Bit xor: carry becomes carry xor selected operand bit.
// - Inverted bit xor: carry xor inverted bit; bit number only immediate.
// - Bit load: selected operand bit is copied into carry.
// - Inverted bit load: inverted operand bit into carry; immediate bit number.
// - Bit store: carry written into selected bit, other bits kept.
// - Inverted bit store: inverted carry into selected bit; immediate bit number.
// - Conditional branch taken only when its sixteen-way condition holds.
// - Exception return ends the handler and resumes interrupted flow.
// - Power-down instruction enters power-down instead of executing on.
// - Control load copies register, memory or immediate into condition or extended reg.
// - Control register memory transfers are words with value in upper eight bits.
// - Control store copies condition or extended register to register or memory.
// - Immediate and, or, xor on a control register, result written back.
// - No-operation only advances the program counter by two.
// - Block copy moves bytes source to destination, both pointers post-increment.
// - Count decrements per byte, stops at zero; zero count copies nothing.
// - Next instruction starts as soon as the block copy completes.
// - Instructions are whole two-byte words of operation, register, extension, condition.
// - Operation field always holds the leading four instruction bits.
// - Address registers take three bits, data registers three or four.
// - Extension is 8, 16 or 32 bits of immediate, address or displacement.
// - Branch condition comes from its own condition field.
// - Non-inverting bit ops take bit number from immediate or register low bits.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module cbbx_core
  import cbbx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic wake,
  input wire logic [15:0] mem_rdata,
  output cbbx_mem_t mem,
  input wire cbbx_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic sleeping,
  output logic illegal
);

  cbbx_core_t s_r;
  cbbx_core_t s_nxt;

  logic [15:0] ir_w;
  logic [3:0] op_w;
  logic [2:0] bfn_w;
  logic bit_inv_w;
  logic [2:0] bit_num_w;
  logic [7:0] opnd_w;
  logic bit_val_w;
  logic bit_go_w;
  logic [7:0] bit_new_w;
  logic c_flag_w;

  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic nv;
    logic r;
    nv = f[CC_N] ^ f[CC_V];
    unique case (cc[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(f[CC_C] | f[CC_Z]);
      3'h2: r = ~f[CC_C];
      3'h3: r = ~f[CC_Z];
      3'h4: r = ~f[CC_V];
      3'h5: r = ~f[CC_N];
      3'h6: r = ~nv;
      3'h7: r = ~(f[CC_Z] | nv);
    endcase
    return r ^ cc[0];
  endfunction

  function automatic cbbx_mem_t rd_req(input logic [23:0] a, input logic b);
    cbbx_mem_t m;
    m = '0;
    m.rd = 1'b1;
    m.addr = a;
    m.byte_acc = b;
    return m;
  endfunction

  function automatic cbbx_mem_t wr_req(input logic [23:0] a, input logic b, input logic [15:0] d);
    cbbx_mem_t m;
    m = '0;
    m.wr = 1'b1;
    m.addr = a;
    m.byte_acc = b;
    m.wdata = d;
    return m;
  endfunction

  // Operand selection for the carry bit group, shared by register and memory forms.
  always_comb begin
    ir_w = (s_r.st == ST_DECODE) ? mem_rdata : s_r.ir;
    op_w = ir_w[15:12];
    bfn_w = ir_w[11:9];
    bit_inv_w = (bfn_w == BF_IXOR) || (bfn_w == BF_ILD) || (bfn_w == BF_IST);
    // Inverting forms ignore the register-select bit.
    if (ir_w[8] && !bit_inv_w) begin
      bit_num_w = s_r.gpr[ir_w[2:0]][2:0];
    end else begin
      bit_num_w = ir_w[2:0];
    end
    if (s_r.st == ST_BIT_RD) begin
      opnd_w = mem_rdata[7:0];
    end else if (ir_w[3]) begin
      opnd_w = s_r.gpr[ir_w[6:4]][7:0];
    end else begin
      opnd_w = s_r.gpr[ir_w[6:4]][15:8];
    end
    bit_val_w = opnd_w[bit_num_w];
    c_flag_w = s_r.condition_code_reg[CC_C];
    bit_go_w = s_r.rvalid && ((s_r.st == ST_BIT_RD) ||
               (s_r.st == ST_DECODE && op_w == OP_BIT && !ir_w[7]));
    bit_new_w = opnd_w;
    bit_new_w[bit_num_w] = (bfn_w == BF_IST) ? ~c_flag_w : c_flag_w;
  end

  always_comb begin
    logic [7:0] cval;
    logic [15:0] cnt;
    logic [31:0] sp;
    cval = 8'h00;
    cnt = 16'h0000;
    sp = s_r.gpr[REG_SP];
    s_nxt = s_r;
    s_nxt.mem.rd = 1'b0;
    s_nxt.mem.wr = 1'b0;
    s_nxt.rvalid = s_r.mem.rd;
    s_nxt.reg_rdata = 32'h00000000;

    if (reg_req.rd) begin
      unique case (reg_req.addr)
        RA_CTRL: s_nxt.reg_rdata[CTRL_RUN] = s_r.run;
        RA_STATUS: s_nxt.reg_rdata = {30'h00000000, s_r.illegal, s_r.sleeping};
        RA_PC: s_nxt.reg_rdata = {8'h00, s_r.pc};
        RA_FLAGS: s_nxt.reg_rdata = {16'h0000, s_r.extended_ctrl_reg, s_r.condition_code_reg};
        default: s_nxt.reg_rdata = 32'h00000000;
      endcase
    end
    if (reg_req.wr && reg_req.addr == RA_CTRL) begin
      s_nxt.run = reg_req.wdata[CTRL_RUN];
    end
    if (reg_req.wr && reg_req.addr == RA_STATUS && reg_req.wdata[STAT_ILLEGAL]) begin
      s_nxt.illegal = 1'b0;
    end

    // Carry group results, from either operand path.
    if (bit_go_w) begin
      s_nxt.pend = 1'b0;
      s_nxt.st = ST_FETCH;
      unique case (bfn_w)
        BF_XOR: s_nxt.condition_code_reg[CC_C] = c_flag_w ^ bit_val_w;
        BF_IXOR: s_nxt.condition_code_reg[CC_C] = c_flag_w ^ ~bit_val_w;
        BF_LD: s_nxt.condition_code_reg[CC_C] = bit_val_w;
        BF_ILD: s_nxt.condition_code_reg[CC_C] = ~bit_val_w;
        BF_ST, BF_IST: begin
          if (s_r.st == ST_BIT_RD) begin
            s_nxt.mem = wr_req(s_r.gpr[ir_w[6:4]][23:0], 1'b1, {8'h00, bit_new_w});
          end else if (ir_w[3]) begin
            s_nxt.gpr[ir_w[6:4]][7:0] = bit_new_w;
          end else begin
            s_nxt.gpr[ir_w[6:4]][15:8] = bit_new_w;
          end
        end
        default: s_nxt.illegal = 1'b1;
      endcase
    end

    unique case (s_r.st)
      ST_FETCH: begin
        if (s_r.run && !s_r.pend) begin
          s_nxt.mem = rd_req(s_r.pc, 1'b0);
          s_nxt.pc = s_r.pc + PC_STEP;
          s_nxt.pend = 1'b1;
          s_nxt.st = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (s_r.rvalid) begin
          s_nxt.ir = mem_rdata;
          s_nxt.pend = 1'b0;
          s_nxt.st = ST_FETCH;
          if (ir_w[11]) begin
            cval = s_r.extended_ctrl_reg;
          end else begin
            cval = s_r.condition_code_reg;
          end
          unique case (op_w)
            OP_NOP: s_nxt.st = ST_FETCH;
            OP_BIT: begin
              if (ir_w[7]) begin
                s_nxt.mem = rd_req(s_r.gpr[ir_w[6:4]][23:0], 1'b1);
                s_nxt.pend = 1'b1;
                s_nxt.st = ST_BIT_RD;
              end
            end
            OP_BCC: begin
              if (cond_true(ir_w[11:8], s_r.condition_code_reg)) begin
                s_nxt.pc = s_r.pc + {{16{ir_w[7]}}, ir_w[7:0]};
              end
            end
            OP_JMP: s_nxt.st = ST_EXT_HI;
            OP_BSR: begin
              s_nxt.tgt = s_r.pc + {{16{ir_w[7]}}, ir_w[7:0]};
              s_nxt.st = ST_PUSH_HI;
            end
            OP_RTS: begin
              s_nxt.mem = rd_req(sp[23:0], 1'b0);
              s_nxt.pend = 1'b1;
              s_nxt.st = ST_POP_HI;
            end
            OP_RTE: begin
              s_nxt.mem = rd_req(sp[23:0], 1'b0);
              s_nxt.pend = 1'b1;
              s_nxt.st = ST_POP_CCR;
            end
            OP_SLP: s_nxt.st = ST_SLEEP;
            OP_LDC: begin
              unique case (ir_w[10:9])
                LS_REG: cval = s_r.gpr[ir_w[6:4]][7:0];
                LS_IMM: cval = ir_w[7:0];
                default: cval = cval;
              endcase
              if (ir_w[10:9] == LS_MEM) begin
                s_nxt.mem = rd_req(s_r.gpr[ir_w[6:4]][23:0], 1'b0);
                s_nxt.pend = 1'b1;
                s_nxt.st = ST_LDC_RD;
              end else if (ir_w[10:9] == LS_REG || ir_w[10:9] == LS_IMM) begin
                if (ir_w[11]) begin
                  s_nxt.extended_ctrl_reg = cval;
                end else begin
                  s_nxt.condition_code_reg = cval;
                end
              end else begin
                s_nxt.illegal = 1'b1;
              end
            end
            OP_STC: begin
              if (ir_w[10]) begin
                s_nxt.mem = wr_req(s_r.gpr[ir_w[6:4]][23:0], 1'b0, {cval, 8'h00});
              end else begin
                s_nxt.gpr[ir_w[6:4]][7:0] = cval;
              end
            end
            OP_LOGC: begin
              unique case (ir_w[10:9])
                LF_AND: cval = cval & ir_w[7:0];
                LF_OR: cval = cval | ir_w[7:0];
                LF_XOR: cval = cval ^ ir_w[7:0];
                default: s_nxt.illegal = 1'b1;
              endcase
              if (ir_w[11]) begin
                s_nxt.extended_ctrl_reg = cval;
              end else begin
                s_nxt.condition_code_reg = cval;
              end
            end
            OP_COPY: begin
              cnt = ir_w[11] ? s_r.gpr[REG_COUNT][15:0] : {8'h00, s_r.gpr[REG_COUNT][7:0]};
              if (cnt != 16'h0000) begin
                s_nxt.st = ST_CPY;
              end
            end
            default: s_nxt.illegal = 1'b1;
          endcase
        end
      end
      ST_EXT_HI, ST_EXT_LO: begin
        if (s_r.rvalid) begin
          s_nxt.pend = 1'b0;
          if (s_r.st == ST_EXT_HI) begin
            s_nxt.tgt = {mem_rdata[7:0], 16'h0000};
            s_nxt.st = ST_EXT_LO;
          end else if (s_r.ir[11]) begin
            s_nxt.tgt = {s_r.tgt[23:16], mem_rdata};
            s_nxt.st = ST_PUSH_HI;
          end else begin
            s_nxt.pc = {s_r.tgt[23:16], mem_rdata};
            s_nxt.st = ST_FETCH;
          end
        end else if (!s_r.pend) begin
          s_nxt.mem = rd_req(s_r.pc, 1'b0);
          s_nxt.pc = s_r.pc + PC_STEP;
          s_nxt.pend = 1'b1;
        end
      end
      ST_PUSH_HI: begin
        sp = s_r.gpr[REG_SP] - SP_FRAME;
        s_nxt.gpr[REG_SP] = sp;
        s_nxt.mem = wr_req(sp[23:0], 1'b0, {8'h00, s_r.pc[23:16]});
        s_nxt.st = ST_PUSH_LO;
      end
      ST_PUSH_LO: begin
        sp = s_r.gpr[REG_SP] + SP_WORD;
        s_nxt.mem = wr_req(sp[23:0], 1'b0, s_r.pc[15:0]);
        s_nxt.pc = s_r.tgt;
        s_nxt.st = ST_FETCH;
      end
      ST_POP_CCR, ST_POP_HI, ST_POP_LO: begin
        if (s_r.rvalid) begin
          s_nxt.pend = 1'b0;
          sp = s_r.gpr[REG_SP] + SP_WORD;
          s_nxt.gpr[REG_SP] = sp;
          if (s_r.st == ST_POP_CCR) begin
            s_nxt.condition_code_reg = mem_rdata[15:8];
            s_nxt.st = ST_POP_HI;
          end else if (s_r.st == ST_POP_HI) begin
            s_nxt.tgt = {mem_rdata[7:0], 16'h0000};
            s_nxt.st = ST_POP_LO;
          end else begin
            s_nxt.pc = {s_r.tgt[23:16], mem_rdata};
            s_nxt.st = ST_FETCH;
          end
        end else if (!s_r.pend) begin
          s_nxt.mem = rd_req(sp[23:0], 1'b0);
          s_nxt.pend = 1'b1;
        end
      end
      ST_LDC_RD: begin
        if (s_r.rvalid) begin
          s_nxt.pend = 1'b0;
          s_nxt.st = ST_FETCH;
          if (s_r.ir[11]) begin
            s_nxt.extended_ctrl_reg = mem_rdata[15:8];
          end else begin
            s_nxt.condition_code_reg = mem_rdata[15:8];
          end
        end
      end
      ST_BIT_RD: s_nxt.st = s_nxt.st;
      ST_CPY: begin
        if (s_r.rvalid) begin
          s_nxt.pend = 1'b0;
          s_nxt.mem = wr_req(s_r.gpr[REG_DST][23:0], 1'b1, {8'h00, mem_rdata[7:0]});
          s_nxt.gpr[REG_SRC] = s_r.gpr[REG_SRC] + PTR_STEP;
          s_nxt.gpr[REG_DST] = s_r.gpr[REG_DST] + PTR_STEP;
          cnt = s_r.gpr[REG_COUNT][15:0] - CNT_STEP;
          if (s_r.ir[11]) begin
            s_nxt.gpr[REG_COUNT][15:0] = cnt;
          end else begin
            s_nxt.gpr[REG_COUNT][7:0] = cnt[7:0];
            cnt[15:8] = 8'h00;
          end
          if (cnt == 16'h0000) begin
            s_nxt.st = ST_FETCH;
          end
        end else if (!s_r.pend) begin
          s_nxt.mem = rd_req(s_r.gpr[REG_SRC][23:0], 1'b1);
          s_nxt.pend = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          s_nxt.st = ST_FETCH;
        end
      end
      default: s_nxt.st = ST_FETCH;
    endcase
    s_nxt.sleeping = (s_nxt.st == ST_SLEEP);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= ST_FETCH;
      s_r.pc <= RESET_PC;
      s_r.condition_code_reg <= CCR_RESET;
      s_r.extended_ctrl_reg <= EXR_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem = s_r.mem;
  assign reg_rdata = s_r.reg_rdata;
  assign sleeping = s_r.sleeping;
  assign illegal = s_r.illegal;

  logic dec_go;
  assign dec_go = (s_r.st == ST_DECODE) && s_r.rvalid;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_fetch_pc_step: assert property (
    s_r.st == ST_FETCH && s_r.run && !s_r.pend |=> s_r.pc == $past(s_r.pc) + PC_STEP && mem.rd)
    else $error("fetch did not step pc by one word");
  chk_xor_carry: assert property (
    bit_go_w && bfn_w == BF_XOR |=> s_r.condition_code_reg[CC_C] == ($past(c_flag_w) ^ $past(bit_val_w)))
    else $error("bit xor carry wrong");
  chk_load_carry: assert property (
    bit_go_w && bfn_w == BF_ILD |=> s_r.condition_code_reg[CC_C] == !$past(bit_val_w))
    else $error("inverted bit load carry wrong");
  chk_store_mem_bit: assert property (
    bit_go_w && bfn_w == BF_IST && s_r.st == ST_BIT_RD
    |=> mem.wr && mem.wdata[$past(bit_num_w)] == !$past(c_flag_w))
    else $error("inverted bit store wrote wrong value");
  chk_branch_never: assert property (
    dec_go && op_w == OP_BCC && ir_w[11:8] == 4'h1 |=> s_r.pc == $past(s_r.pc))
    else $error("never branch moved pc");
  chk_stc_upper_byte: assert property (
    dec_go && op_w == OP_STC && ir_w[10] |=> mem.wr && mem.wdata[7:0] == 8'h00)
    else $error("control store to memory not upper byte");
  chk_copy_zero_count: assert property (
    dec_go && op_w == OP_COPY && s_r.gpr[REG_COUNT][7:0] == 8'h00 && !ir_w[11]
    |=> s_r.st == ST_FETCH ##1 !mem.wr)
    else $error("zero count copy transferred a byte");
  chk_sleep_hold: assert property (
    s_r.st == ST_SLEEP && !wake |=> s_r.st == ST_SLEEP && sleeping && !mem.rd)
    else $error("sleep left without wake");
  chk_ctrl_and_imm_result: assert property (
    dec_go && op_w == OP_LOGC && ir_w[10:9] == LF_AND && !ir_w[11]
    |=> s_r.condition_code_reg == ($past(s_r.condition_code_reg) & $past(ir_w[7:0])))
    else $error("immediate and on condition register wrong");

  cov_copy_run: cover property (s_r.st == ST_CPY ##1 s_r.st == ST_CPY ##1 mem.wr);
  cov_call_return: cover property (s_r.st == ST_PUSH_LO ##[1:40] s_r.st == ST_POP_LO);
  cov_branch_taken: cover property (dec_go && op_w == OP_BCC && cond_true(ir_w[11:8], s_r.condition_code_reg));
  cov_sleep_wake: cover property (s_r.st == ST_SLEEP ##1 s_r.st == ST_FETCH);

endmodule
`default_nettype wire

// [tb/cbbx_mem_model.sv]
// Byte memory of 256 places on the core's private bus, words big-endian.
// Assumes the core's clock and a read answered exactly one cycle later.
`timescale 1ns/1ns
`default_nettype none
module cbbx_mem_model
  import cbbx_pkg::*;
(
  input wire logic clock,
  input wire cbbx_mem_t mem,
  output logic [15:0] mem_rdata
);
  logic [7:0] m [256];
  logic [7:0] a;
  assign a = mem.addr[7:0];
  initial mem_rdata = 16'h0000;
  // Outside a read answer the data lines toggle, so stale data never looks valid.
  always @(posedge clock) begin
    if (mem.rd) begin
      mem_rdata <= mem.byte_acc ? {8'h00, m[a]} : {m[a], m[a + 8'h01]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem.wr && mem.byte_acc) begin
      m[a] <= mem.wdata[7:0];
    end else if (mem.wr) begin
      m[a] <= mem.wdata[15:8];
      m[a + 8'h01] <= mem.wdata[7:0];
    end
  end
endmodule
`default_nettype wire

// [tb/cpu_bit_branch_sysctl_exec_tb_top.sv]
// Self-checking bench for the execute core: random programs, results read back.
// Assumes the memory model above and the register port of the core.
`timescale 1ns/1ns
`default_nettype none
module cpu_bit_branch_sysctl_exec_tb_top;
  import cbbx_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wake = 1'b0;
  logic [15:0] mem_rdata;
  cbbx_mem_t mem;
  cbbx_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  logic sleeping;
  logic illegal;
  int failures = 0;
  int check_count = 0;
  int seed = 13;
  logic [15:0] prog [$];
  cbbx_core u_dut (.clock(clock), .reset(reset), .wake(wake), .mem_rdata(mem_rdata),
    .mem(mem), .reg_req(reg_req), .reg_rdata(reg_rdata), .sleeping(sleeping),
    .illegal(illegal));
  cbbx_mem_model u_mem (.clock(clock), .mem(mem), .mem_rdata(mem_rdata));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    reg_req <= '0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic fill();
    for (int i = 192; i < 256; i++) u_mem.m[i] = 8'($random(seed));
  endtask
  // Loads the program, resets, starts the core and waits for power-down.
  task automatic run(output logic [31:0] flags);
    int i;
    for (i = 0; i < prog.size(); i++) begin
      u_mem.m[2 * i] = prog[i][15:8];
      u_mem.m[2 * i + 1] = prog[i][7:0];
    end
    reset <= 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    reg_wr(RA_CTRL, 32'h1);
    for (i = 0; i < 3000 && sleeping !== 1'b1; i++) @(posedge clock);
    if (i == 3000) begin
      failures++;
      summarize();
    end
    reg_rd(RA_FLAGS, flags);
    prog.delete();
  endtask
  function automatic logic bit_res(input int fn, input logic c, input logic d);
    case (fn)
      0: return c ^ d;
      1: return c ^ ~d;
      2: return d;
      3: return ~d;
      default: return c;
    endcase
  endfunction
  function automatic logic taken(input logic [3:0] cc, input logic [3:0] f);
    logic n, z, v, c, t;
    {n, z, v, c} = f;
    case (cc[3:1])
      3'h0: t = 1'b1;
      3'h1: t = !(c | z);
      3'h2: t = !c;
      3'h3: t = !z;
      3'h4: t = !v;
      3'h5: t = !n;
      3'h6: t = !(n ^ v);
      default: t = !(z | (n ^ v));
    endcase
    return t ^ cc[0];
  endfunction
  function automatic logic [7:0] logc(input int fn, input logic [7:0] a, input logic [7:0] b);
    return fn == 0 ? a & b : fn == 1 ? a | b : a ^ b;
  endfunction
  initial begin
    logic [31:0] fl, rv;
    logic [7:0] d, e;
    logic [7:0] od [4];
    logic [2:0] k;
    logic rm;
    int fn, j, n;
    for (j = 0; j < 256; j++) u_mem.m[j] = 8'h00;
    for (j = 0; j < 36; j++) begin
      fn = j % 6;
      rv = $random(seed);
      fill();
      d = u_mem.m[8'hC0];
      rm = rv[16] && fn % 2 == 0 && fn < 4;
      k = rm ? 3'h0 : rv[2:0];
      // Register-mode bit number comes from the low bits of the pointer, which are zero.
      prog = '{16'h74C0, 16'h8010, {8'h74, rv[15:8]},
        {4'h1, 3'(fn), rm, 4'h9, 1'b0, rm ? 3'h1 : rv[2:0]}, 16'h6000};
      e = d;
      if (fn == 4) e[k] = rv[8];
      if (fn == 5) e[k] = ~rv[8];
      run(fl);
      check(fl[7:0], {rv[15:9], bit_res(fn, rv[8], d[k])});
      check(u_mem.m[8'hC0], e);
    end
    for (j = 0; j < 64; j++) begin
      rv = $random(seed);
      prog = '{{12'h740, rv[3:0]}, {4'h2, 4'(j), 8'h02}, 16'h7C55, 16'h6000};
      run(fl);
      check(fl[15:8], taken(4'(j), rv[3:0]) ? 8'h00 : 8'h55);
    end
    for (j = 0; j < 6; j++) begin
      fn = j % 3;
      rv = $random(seed);
      fill();
      d = u_mem.m[8'hC0];
      // After the wake the core spins on a jump to itself, so it only reads memory.
      prog = '{16'h74C0, 16'h8010, 16'h7210, {4'h9, 1'b0, 2'(fn), 1'b0, rv[7:0]},
        {8'h7C, rv[15:8]}, {4'h9, 1'b1, 2'(fn), 1'b0, rv[23:16]}, 16'h8C10, 16'h0000,
        16'hF000, 16'h6000, 16'h3000, 16'h0000, 16'h0014};
      run(fl);
      e = logc(fn, rv[15:8], rv[23:16]);
      check(fl[15:0], {e, logc(fn, d, rv[7:0])});
      check({u_mem.m[8'hC0], u_mem.m[8'hC1]}, {e, 8'h00});
      reg_rd(RA_STATUS, fl);
      check(fl, 32'h3);
      reg_rd(8'h10, fl);
      check(fl, 32'h0);
      reg_wr(RA_STATUS, 32'h2);
      #1 check(illegal, 1'b0);
      @(posedge clock);
      wake <= 1'b1;
      repeat (3) @(posedge clock);
      wake <= 1'b0;
      #1 check(sleeping, 1'b0);
      @(posedge clock);
    end
    for (j = 0; j < 8; j++) begin
      n = j % 4;
      fill();
      for (int i = 0; i < 4; i++) od[i] = u_mem.m[208 + i];
      prog = '{{8'h74, 8'(n)}, 16'h8040, 16'h74C0, 16'h8050, 16'h74D0, 16'h8060,
        {4'hA, j >= 4, 11'h000}, 16'h7C3C, 16'h6000};
      run(fl);
      for (int i = 0; i < 4; i++) begin
        check(u_mem.m[208 + i], i < n ? u_mem.m[192 + i] : od[i]);
      end
      check(fl[15:8], 8'h3C);
    end
    // Call and return through a stack at 0x80; the return lands on the exr load.
    prog = '{16'h7480, 16'h8070, 16'h4004, 16'h7C11, 16'h6000, 16'h7422, 16'h5000};
    run(fl);
    check(fl[15:0], 16'h1122);
    check({u_mem.m[8'h7E], u_mem.m[8'h7F]}, 16'h0006);
    // Exception return pops the condition word, then the resume address 0x000C.
    for (j = 0; j < 6; j++) u_mem.m[8'h80 + j] = j == 0 ? 8'hAB : j == 5 ? 8'h0C : 8'h00;
    prog = '{16'h7480, 16'h8070, 16'hB000, 16'h6000, 16'h0000, 16'h0000, 16'h7C5A,
      16'h6000};
    run(fl);
    check(fl[15:0], 16'h5AAB);
    summarize();
  end
endmodule
`default_nettype wire
